// File: dv/host_port_model.sv
/*
 Behavioural host serial port facing the converter port: drives the DAC link, receives ADC words.
 Assumes pull-ups on the open-drain ADC pins and a 48 ns link clock that idles high.
*/
`timescale 1ns/1ps
module host_port_model
	import adc_dac_io_pkg::*;
(
	// ADC pins seen by the host.
	input wire od_pin_t sd_pin_in,
	input wire od_pin_t fs_pin_in,
	input wire od_pin_t sck_pin_in,
	// DAC link driven by the host.
	output logic link_clk_out,
	output logic link_frame_n_out,
	output logic link_data_out,
	// Received ADC word and its bit count.
	output logic [WORD_BITS-1:0] rx_word_out,
	output logic [4:0] rx_count_out
);
	logic sd_level;
	logic fs_level;
	logic sck_level;

	// Pull-ups: a pin reads low only while its driver is enabled.
	assign sd_level = (sd_pin_in.oe_n === 1'h0) ? sd_pin_in.out : 1'h1;
	assign fs_level = (fs_pin_in.oe_n === 1'h0) ? fs_pin_in.out : 1'h1;
	assign sck_level = (sck_pin_in.oe_n === 1'h0) ? sck_pin_in.out : 1'h1;

	// The link clock starts high and rests high between pulses.
	initial
	begin
		link_clk_out = 1'h1;
		link_frame_n_out = 1'h1;
		link_data_out = 1'h0;
		rx_word_out = '0;
		rx_count_out = 5'h00;
	end

	// A new frame clears the bit count.
	always @(negedge fs_level)
	begin
		rx_count_out = 5'h00;
	end

	// The first 16 bits are read just after falling serial clock edges while framed.
	always @(negedge sck_level)
	begin
		#1;
		if (!fs_level && rx_count_out < 5'h10)
		begin
			rx_word_out = {rx_word_out[WORD_BITS-2:0], sd_level};
			rx_count_out = rx_count_out + 5'h01;
		end
	end

	// Clock pulses with the frame high; the data line wanders meanwhile.
	task automatic idle_pulses(input int n);
		for (int i = 0; i < n; i++)
		begin
			link_data_out = 1'($urandom);
			#24 link_clk_out = 1'h0;
			#24 link_clk_out = 1'h1;
		end
	endtask

	// One framed word, MSB first; data changes while the clock is high.
	task automatic send_word(input logic [WORD_BITS-1:0] w);
		link_frame_n_out = 1'h0;
		for (int i = WORD_BITS - 1; i >= 0; i--)
		begin
			link_data_out = w[i];
			#24 link_clk_out = 1'h0;
			#24 link_clk_out = 1'h1;
		end
		link_frame_n_out = 1'h1;
		// Released data shows the inverse so a stale bit cannot pass.
		link_data_out = ~w[0];
		#24; // The frame stands high for half a clock before the next word.
	endtask
endmodule // host_port_model

// File: dv/serial_adc_dac_io_port_tb_top.sv
/*
 Self-checking bench for the converter port: ADC words, strap modes and DAC latch updates.
 Assumes the host model drives the link; expected values wait in queues for the monitors.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin err_total++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module serial_adc_dac_io_port_tb_top;
	import adc_dac_io_pkg::*;
	logic clk_sys_in = 1'h0;
	logic reset_n_in = 1'h0;
	gate_mode_t gate = GATE_GROUND;
	logic osc = 1'h0;
	logic adc_clk = 1'h0;
	logic conv_start = 1'h0;
	logic [DATA_BITS-1:0] adc_result = '0;
	logic dac_load_n = 1'h1;
	logic link_clk;
	logic link_frame_n;
	logic link_data;
	od_pin_t sd_pin;
	od_pin_t fs_pin;
	od_pin_t sck_pin;
	logic hold;
	logic [DATA_BITS-1:0] latch;
	logic [WORD_BITS-1:0] rx_word;
	logic [4:0] rx_count;
	logic [WORD_BITS-1:0] exp_adc[$];
	logic [DATA_BITS-1:0] exp_dac[$];
	logic [WORD_BITS-1:0] exp_w;
	logic [DATA_BITS-1:0] exp_d;
	logic dac_watch = 1'h0;
	int err_total = 0;
	int n_tests = 0;
	int cyc_total = 0;
	localparam int START_GAP_CYC = 12000 / SYS_CLK_NS;
	int last_start = -START_GAP_CYC;
	gate_mode_t cfg_gate[5] = '{GATE_GROUND, GATE_NEG, GATE_GROUND, GATE_NEG, GATE_TEST};
	logic cfg_osc[5] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0};

	serial_adc_dac_io_port i_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.clock_gating_select_in(gate), .int_osc_select_in(osc), .adc_clock_in(adc_clk),
		.convert_start_in(conv_start), .adc_result_in(adc_result), .adc_serial_out(sd_pin),
		.adc_frame_n_out(fs_pin), .adc_serial_clock_out(sck_pin), .adc_hold_out(hold),
		.dac_serial_clock_in(link_clk), .dac_frame_n_in(link_frame_n),
		.dac_serial_in(link_data), .dac_load_n_in(dac_load_n), .dac_latch_out(latch));

	host_port_model i_host (.sd_pin_in(sd_pin), .fs_pin_in(fs_pin), .sck_pin_in(sck_pin),
		.link_clk_out(link_clk), .link_frame_n_out(link_frame_n), .link_data_out(link_data),
		.rx_word_out(rx_word), .rx_count_out(rx_count));

	// System clock at 25 MHz and a 2 MHz external ADC clock off its phase.
	always #20 clk_sys_in = ~clk_sys_in;
	always #250.3 adc_clk = ~adc_clk;

	// Cuts a hang short.
	always @(posedge clk_sys_in)
	begin
		cyc_total++;
		if (cyc_total == 20000)
		begin
			err_total++;
			finish_test();
		end
	end

	// Each finished ADC frame is compared with the oldest expected word.
	always @(posedge fs_pin.oe_n)
	begin
		#1;
		if (reset_n_in === 1'h1)
		begin
			exp_w = (exp_adc.size() > 0) ? exp_adc.pop_front() : ~rx_word;
			`CHK("adc_word", exp_w, rx_word)
			`CHK("adc_bits", 5'h10, rx_count)
		end
	end

	// Each DAC latch change is compared with the oldest expected value.
	always @(latch)
	begin
		if (dac_watch)
		begin
			exp_d = (exp_dac.size() > 0) ? exp_dac.pop_front() : ~latch;
			`CHK("dac_latch", exp_d, latch)
		end
	end

	task automatic finish_test();
		if (err_total == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Reset with new straps; the link clock pulses so its domain clears too.
	task automatic do_reset(input gate_mode_t g, input logic o);
		@(posedge clk_sys_in) #2;
		reset_n_in = 1'h0;
		gate = g;
		osc = o;
		i_host.idle_pulses(4);
		repeat (2) @(posedge clk_sys_in);
		#2 reset_n_in = 1'h1;
		@(posedge clk_sys_in) #2;
		`CHK("reset_pins", 3'h6, {fs_pin.oe_n, sd_pin.oe_n, hold})
		`CHK("reset_latch", 14'h0000, latch)
		// Link edges after release let the link-domain reset clear.
		i_host.idle_pulses(3);
	endtask

	// One conversion; a second start in mid-conversion must be ignored.
	task automatic run_conv(input logic test_mode, input logic restart);
		int cyc;
		logic [DATA_BITS-1:0] r;
		cyc = 0;
		r = DATA_BITS'($urandom);
		// Starts stay at least 12 us apart.
		while (cyc_total < last_start + START_GAP_CYC)
			@(posedge clk_sys_in);
		@(posedge clk_sys_in) #2;
		adc_result = r;
		conv_start = 1'h1;
		last_start = cyc_total;
		if (!test_mode)
			exp_adc.push_back({LEAD_ZEROS, r});
		repeat (20) @(posedge clk_sys_in);
		`CHK("adc_hold", ~test_mode, hold)
		if (restart)
		begin
			#2 conv_start = 1'h0;
			repeat (4) @(posedge clk_sys_in);
			cyc = 4;
			#2 conv_start = 1'h1;
		end
		while (hold === 1'h1 && cyc < 700)
		begin
			@(posedge clk_sys_in);
			cyc++;
		end
		#2 conv_start = 1'h0;
		`CHK("adc_hold_end", 1'h0, hold)
		if (osc)
			`CHK("conv_time", 1'h1, cyc + 20 <= INT_CONV_MAX_CYC)
	endtask

	// Words with load held low, then a word held until a load fall.
	task automatic dac_tests();
		logic [WORD_BITS-1:0] w;
		dac_watch = 1'h1;
		@(posedge clk_sys_in) #2;
		dac_load_n = 1'h0;
		repeat (6) @(posedge clk_sys_in);
		for (int i = 0; i < 3; i++)
		begin
			w = WORD_BITS'($urandom);
			exp_dac.push_back(w[DATA_BITS-1:0]);
			i_host.send_word(w);
		end
		i_host.idle_pulses(8);
		@(posedge clk_sys_in) #2;
		dac_load_n = 1'h1;
		repeat (10) @(posedge clk_sys_in);
		w = WORD_BITS'($urandom);
		i_host.send_word(w);
		repeat (20) @(posedge clk_sys_in);
		exp_dac.push_back(w[DATA_BITS-1:0]);
		#2 dac_load_n = 1'h0;
		repeat (10) @(posedge clk_sys_in);
		`CHK("dac_pending", 0, exp_dac.size())
		dac_watch = 1'h0;
	endtask

	// Five strap settings: conversions, then the serial clock while idle.
	initial
	begin
		int toggles;
		logic last;
		void'($urandom(32'he2d7f4a8));
		for (int k = 0; k < 5; k++)
		begin
			do_reset(cfg_gate[k], cfg_osc[k]);
			if (k == 0)
				dac_tests();
			run_conv(k == 4, 1'h0);
			run_conv(k == 4, 1'h1);
			repeat (40) @(posedge clk_sys_in);
			toggles = 0;
			last = sck_pin.oe_n;
			for (int i = 0; i < 50; i++)
			begin
				@(posedge clk_sys_in) #2;
				toggles += int'(sck_pin.oe_n !== last);
				last = sck_pin.oe_n;
			end
			`CHK("sck_runs", gate == GATE_NEG, toggles > 0)
			if (gate != GATE_NEG)
				`CHK("sck_released", 1'h1, sck_pin.oe_n)
		end
		`CHK("adc_pending", 0, exp_adc.size())
		finish_test();
	end
endmodule // serial_adc_dac_io_port_tb_top

// File: hdl/adc_dac_io_pkg.sv
/*
 Shared constants and types for the serial ADC/DAC port control block.
 Assumes a 25 MHz system clock and a separate DAC serial clock from the host.
*/
package adc_dac_io_pkg;
	localparam int SYS_CLK_NS = 40;
	localparam int START_SETUP_NS = 30;
	localparam int INT_CONV_MAX_NS = 10000;
	localparam int CONV_EDGES_SHORT = 19;
	localparam int CONV_EDGES_LONG = 20;
	localparam int WORD_BITS = 16;
	localparam int DATA_BITS = 14;
	// Least time rounds up, longest time rounds down.
	localparam int START_SETUP_CYC = (START_SETUP_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int INT_CONV_MAX_CYC = INT_CONV_MAX_NS / SYS_CLK_NS;
	localparam int OSC_HALF_CYC = INT_CONV_MAX_NS / (2 * CONV_EDGES_LONG * SYS_CLK_NS);
	localparam logic [4:0] EDGES_SHORT = 5'h13;
	localparam logic [4:0] EDGES_LONG = 5'h14;
	localparam logic [4:0] WORD_LAST = 5'h0f;
	localparam logic [1:0] LEAD_ZEROS = 2'h0;

	// Three-level strap on the clock gating select pin.
	typedef enum logic [1:0] {
		GATE_GROUND = 2'h0,
		GATE_NEG = 2'h1,
		GATE_TEST = 2'h2
	} gate_mode_t;

	// Gray-coded conversion states.
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_CONV = 2'h1,
		ST_TEST = 2'h3
	} conv_state_t;

	// Open-drain pin: out is the level driven, oe_n low while driving.
	typedef struct packed {
		logic out;
		logic oe_n;
	} od_pin_t;
endpackage

// File: hdl/serial_adc_dac_io_port.sv
/*
 Control and serial interface logic of a combined 14-bit ADC and 14-bit DAC.
 Assumes the SAR core presents its result on adc_result_in in the system domain,
 the straps are stable during reset, and the DAC serial clock is a separate domain.
*/
`timescale 1ns/1ps
module serial_adc_dac_io_port
	import adc_dac_io_pkg::*;
(
	// System clock and reset.
	input wire logic clk_sys_in,
	input wire logic reset_n_in,
	// Straps.
	input wire gate_mode_t clock_gating_select_in,
	input wire logic int_osc_select_in,
	// ADC pins and core.
	input wire logic adc_clock_in,
	input wire logic convert_start_in,
	input wire logic [DATA_BITS-1:0] adc_result_in,
	output od_pin_t adc_serial_out,
	output od_pin_t adc_frame_n_out,
	output od_pin_t adc_serial_clock_out,
	output logic adc_hold_out,
	// DAC pins and latch.
	input wire logic dac_serial_clock_in,
	input wire logic dac_frame_n_in,
	input wire logic dac_serial_in,
	input wire logic dac_load_n_in,
	output logic [DATA_BITS-1:0] dac_latch_out
);
	gate_mode_t gate_mode;
	logic use_int_osc;
	conv_state_t state;
	logic conv_s1, conv_s2, conv_s3, start_pulse;
	logic clk_s1, clk_s2;
	logic [3:0] osc_cnt;
	logic osc_lvl, adc_lvl, adc_lvl_d, adc_rise, adc_fall;
	logic [4:0] edge_cnt;
	logic need_long;
	logic [1:0] win_cnt;
	logic fell_seen;
	logic [WORD_BITS-1:0] adc_shift;
	logic [4:0] bits_sent;
	logic conv_end, nc_internal;
	logic [7:0] conv_cycles;
	logic lrst_s1, lrst_n;
	logic [WORD_BITS-1:0] dac_shift;
	logic [3:0] dac_bits;
	logic [DATA_BITS-1:0] input_latch;
	logic word_tgl;
	logic tgl_s1, tgl_s2, tgl_s3, word_done;
	logic dac_busy, busy_s1, busy_s2;
	logic load_s1, load_s2, load_s3, load_fall;
	logic [DATA_BITS-1:0] input_copy;

	// Straps are caught while reset is held.
	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in)
		begin
			gate_mode <= clock_gating_select_in;
			use_int_osc <= int_osc_select_in;
		end
	end

	assign nc_internal = use_int_osc && (gate_mode == GATE_GROUND);

	// Asynchronous convert start and external clock pass two flops first.
	always_ff @(posedge clk_sys_in)
	begin
		conv_s1 <= convert_start_in;
		conv_s2 <= conv_s1;
		conv_s3 <= conv_s2;
		clk_s1 <= adc_clock_in;
		clk_s2 <= clk_s1;
	end

	assign start_pulse = conv_s2 && !conv_s3;

	// Internal oscillator; in gated mode it only runs during a conversion.
	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in || !use_int_osc || (gate_mode != GATE_NEG && state != ST_CONV))
		begin
			osc_cnt <= 4'h0;
			osc_lvl <= 1'b0;
		end
		else if (osc_cnt == 4'(OSC_HALF_CYC - 1))
		begin
			osc_cnt <= 4'h0;
			osc_lvl <= !osc_lvl;
		end
		else
			osc_cnt <= osc_cnt + 4'h1;
	end

	// Selected ADC clock level and its edges.
	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in)
		begin
			adc_lvl <= 1'b0;
			adc_lvl_d <= 1'b0;
		end
		else
		begin
			adc_lvl <= use_int_osc ? osc_lvl : clk_s2;
			adc_lvl_d <= adc_lvl;
		end
	end

	assign adc_rise = adc_lvl && !adc_lvl_d;
	assign adc_fall = !adc_lvl && adc_lvl_d;
	assign conv_end = (state == ST_CONV) && adc_rise
		&& (edge_cnt == (need_long ? EDGES_LONG : EDGES_SHORT) - 5'h1);

	// Conversion sequencing.
	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in)
			state <= (gate_mode == GATE_TEST) ? ST_TEST : ST_IDLE;
		else
		begin
			case (state)
				ST_IDLE:
					if (gate_mode == GATE_TEST)
						state <= ST_TEST;
					else if (start_pulse)
						state <= ST_CONV;
				ST_CONV:
					if (conv_end)
						state <= ST_IDLE;
				ST_TEST:
					state <= ST_TEST;
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// Edge count and the 19/20 decision from start-to-clock alignment.
	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in || state != ST_CONV)
		begin
			edge_cnt <= 5'h0;
			need_long <= 1'b0;
			win_cnt <= 2'(START_SETUP_CYC);
		end
		else
		begin
			if (win_cnt != 2'h0)
				win_cnt <= win_cnt - 2'h1;
			if (adc_rise)
				edge_cnt <= edge_cnt + 5'h1;
			if (adc_rise && win_cnt != 2'h0 && !nc_internal)
				need_long <= 1'b1;
		end
	end

	// Output word shifts on rising ADC clock after its bit saw a falling edge.
	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in)
		begin
			adc_shift <= {WORD_BITS{1'b1}};
			bits_sent <= 5'h0;
			fell_seen <= 1'b0;
		end
		else if (state == ST_IDLE && start_pulse)
		begin
			adc_shift <= {LEAD_ZEROS, adc_result_in};
			bits_sent <= 5'h0;
			fell_seen <= 1'b0;
		end
		else if (state == ST_CONV)
		begin
			if (adc_fall || (gate_mode != GATE_NEG && !adc_lvl))
				fell_seen <= 1'b1;
			if (adc_rise && fell_seen && bits_sent <= WORD_LAST)
			begin
				adc_shift <= {adc_shift[WORD_BITS-2:0], 1'b1};
				bits_sent <= bits_sent + 5'h1;
			end
		end
	end

	// Open-drain pins are driven low only; registered straight to the pads.
	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in)
		begin
			adc_serial_out <= '{out: 1'b0, oe_n: 1'b1};
			adc_frame_n_out <= '{out: 1'b0, oe_n: 1'b1};
			adc_serial_clock_out <= '{out: 1'b0, oe_n: 1'b1};
			adc_hold_out <= 1'b0;
		end
		else
		begin
			adc_hold_out <= (state == ST_CONV);
			adc_frame_n_out.oe_n <= (state != ST_CONV);
			adc_serial_out.oe_n <= !(state == ST_CONV && !adc_shift[WORD_BITS-1]);
			adc_serial_clock_out.oe_n <= !(((gate_mode == GATE_NEG) || state == ST_CONV)
				&& state != ST_TEST && !adc_lvl);
		end
	end

	// Link-domain reset, synchronised to the DAC serial clock.
	always_ff @(negedge dac_serial_clock_in)
	begin
		lrst_s1 <= reset_n_in;
		lrst_n <= lrst_s1;
	end

	// DAC input shift register on falling DAC clock edges while framed.
	always_ff @(negedge dac_serial_clock_in)
	begin
		if (!lrst_n)
		begin
			dac_shift <= '0;
			dac_bits <= 4'h0;
			input_latch <= '0;
			word_tgl <= 1'b0;
			dac_busy <= 1'b0;
		end
		else if (!dac_frame_n_in)
		begin
			dac_shift <= {dac_shift[WORD_BITS-2:0], dac_serial_in};
			dac_bits <= dac_bits + 4'h1;
			dac_busy <= (dac_bits != 4'hf); // Registered so the crossing level cannot glitch.
			if (dac_bits == 4'hf)
			begin
				input_latch <= {dac_shift[DATA_BITS-2:0], dac_serial_in};
				word_tgl <= !word_tgl;
			end
		end
	end

	// Word-complete toggle, transfer-busy level and load strobe cross over.
	always_ff @(posedge clk_sys_in)
	begin
		tgl_s1 <= word_tgl;
		tgl_s2 <= tgl_s1;
		tgl_s3 <= tgl_s2;
		busy_s1 <= dac_busy;
		busy_s2 <= busy_s1;
		load_s1 <= dac_load_n_in;
		load_s2 <= load_s1;
		load_s3 <= load_s2;
	end

	assign word_done = tgl_s2 ^ tgl_s3;
	assign load_fall = load_s3 && !load_s2;

	// Input latch copy and DAC latch update.
	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in)
		begin
			input_copy <= '0;
			dac_latch_out <= '0;
		end
		else
		begin
			if (word_done)
				input_copy <= input_latch;
			if (word_done && !load_s2)
				dac_latch_out <= input_latch;
			else if (load_fall && !busy_s2)
				dac_latch_out <= input_copy;
		end
	end

	// Helper: cycles spent in a conversion.
	always_ff @(posedge clk_sys_in)
	begin
		if (!reset_n_in || state != ST_CONV)
			conv_cycles <= 8'h0;
		else if (conv_cycles != 8'hff)
			conv_cycles <= conv_cycles + 8'h1;
	end

	// Released data whenever the frame is released.
	chk_frame_data_idle: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		adc_frame_n_out.oe_n |-> adc_serial_out.oe_n)
		else $error("data driven outside frame");

	// Start edge reaches hold and frame two cycles after the synchroniser.
	chk_start_holds: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		start_pulse && state == ST_IDLE && gate_mode != GATE_TEST
		|=> ##1 adc_hold_out && !adc_frame_n_out.oe_n)
		else $error("start did not hold and frame");

	// Input edge is seen only after two synchroniser stages.
	chk_start_sync: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		$rose(conv_s1) && state == ST_IDLE && gate_mode != GATE_TEST
		|=> ##1 state == ST_CONV)
		else $error("start not synchronised in two stages");

	// Gated clock stays released while idle.
	chk_gated_clock: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		gate_mode == GATE_GROUND && state == ST_IDLE && $past(state) == ST_IDLE
		|=> adc_serial_clock_out.oe_n)
		else $error("gated clock ran outside conversion");

	// Test mode releases every ADC pin.
	chk_test_quiet: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		state == ST_TEST |=> adc_frame_n_out.oe_n && adc_serial_out.oe_n
		&& adc_serial_clock_out.oe_n && !adc_hold_out)
		else $error("activity in test mode");

	// Conversion lasts 19 or 20 rising edges.
	chk_conv_edges: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		conv_end |-> edge_cnt == 5'h12 || edge_cnt == 5'h13)
		else $error("conversion edge count wrong");

	// Early rise forces the long conversion.
	chk_setup_long: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		state == ST_CONV && $past(state) == ST_IDLE && adc_rise && !nc_internal
		|=> need_long)
		else $error("close start did not give 20 edges");

	// Gated internal oscillator always gives 19 edges.
	chk_nc_short: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		nc_internal && conv_end |-> !need_long && edge_cnt == 5'h12)
		else $error("gated oscillator conversion not 19 edges");

	// Internal oscillator conversion bounded in time.
	chk_int_time: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		use_int_osc |-> conv_cycles <= 8'(INT_CONV_MAX_CYC))
		else $error("internal conversion too long");

	// First bit on the line is a leading zero.
	chk_first_zero: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		$rose(adc_hold_out) |-> !adc_serial_out.oe_n [*2])
		else $error("first bit not a leading zero");

	// Load fall between words copies the input latch.
	chk_dac_load: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		load_fall && !busy_s2 && !word_done |=> dac_latch_out == $past(input_copy))
		else $error("load strobe did not update DAC latch");

	// Word completion with load held low updates the DAC latch.
	chk_dac_auto: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		word_done && !load_s2 |=> dac_latch_out == $past(input_latch))
		else $error("held load did not update at word end");

	// Unframed DAC clock edges leave the shift register alone.
	chk_dac_ignore: assert property (@(negedge dac_serial_clock_in) disable iff (!lrst_n)
		dac_frame_n_in |=> $stable(dac_shift) && $stable(dac_bits))
		else $error("unframed DAC bit accepted");

	// Main scenarios.
	cov_long_conv: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		conv_end && need_long);
	cov_short_conv: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		conv_end && !need_long);
	cov_auto_load: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		word_done && !load_s2);
	cov_strobe_load: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		load_fall && !busy_s2);
endmodule // serial_adc_dac_io_port
